// File: src/code_lock_defines.svh
`ifndef CODE_LOCK_DEFINES_SVH
`define CODE_LOCK_DEFINES_SVH
// image layout
`define IMG_CODE_LAST 15'h3FFF
`define IMG_KEY_BASE 15'h4000
`define IMG_KEY_LAST 15'h403F
`define IMG_LOCK_ADDR 15'h4040
// lock byte field positions, 0 = protection enabled
`define LOCK_POS_ONE 0
`define LOCK_POS_TWO 1
`define LOCK_POS_THREE 2
`define KEY_BLANK 8'hFF
`define BYTE_ZERO 8'h00
`define LEVEL_NONE 4'h0
// sync stages and the wait before the one-shot capture
`define SYNC_CLEAR 2'h0
`define SETTLE_START 2'h2
`define SETTLE_STEP 2'h1
`define SETTLE_DONE 2'h0
`endif

// File: src/code_lock_pkg.sv
package code_lock_pkg;
   typedef enum logic [3:0] {
      LVL_OPEN = 4'h1,
      LVL_ONE = 4'h2,
      LVL_TWO = 4'h4,
      LVL_ALL = 4'h8
   } lock_level_t;
endpackage

// File: src/code_security_lock.sv
`timescale 1ns/10ps
`include "code_lock_defines.svh"
// Overview of operation
// RQ1 - unlocked part allows verify; output encrypted when key table programmed
// RQ2 - bit one blocks external table reads from fetching internal code
// RQ3 - bit one latches external access pin at reset, holds until next reset
// RQ4 - bit one rejects all further programming of program memory
// RQ5 - bits one and two also disable verify mode
// RQ6 - all three bits also refuse execution from external memory
// RQ7 - programmer uses only the four cumulative lock patterns
// RQ8 - bit two takes effect only together with bit one
// RQ9 - image holds code 0000H-3FFFH, key 4000H-403FH, FFH means none
// RQ10 - lock byte at 4040H, bits 0..2, zero enables protection
// RQ11 - verify output is xnor of code and key byte; key never readable
// RQ12 - lock bits read during reset, level held in flip-flops
module code_security_lock
   import code_lock_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // nonvolatile lock byte and key state
   input wire logic [7:0] lock_byte,
   input wire logic key_programmed,
   // external access pin
   input wire logic external_access_pin,
   // requests from core and programmer
   input wire logic verify_req,
   input wire logic [14:0] verify_addr,
   input wire logic [7:0] code_byte,
   input wire logic [7:0] key_byte,
   input wire logic program_req,
   input wire logic code_table_read_instr,
   input wire logic fetch_from_external,
   input wire logic ext_fetch_req,
   // grants and status
   output logic [7:0] verify_data,
   output logic verify_valid,
   output logic program_allow,
   output logic table_read_allow,
   output logic ext_exec_allow,
   output logic ea_latched,
   output logic [3:0] lock_level
);
   // ==========================================================
   // pin synchronisers
   // each pin input crosses two flops; only the second stage is read
   logic [1:0] ea_sync_r;
   logic [1:0] vreq_sync_r;
   logic [1:0] preq_sync_r;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ea_sync_r <= `SYNC_CLEAR;
      end else begin
         ea_sync_r <= {ea_sync_r[0], external_access_pin};
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         vreq_sync_r <= `SYNC_CLEAR;
      end else begin
         vreq_sync_r <= {vreq_sync_r[0], verify_req};
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         preq_sync_r <= `SYNC_CLEAR;
      end else begin
         preq_sync_r <= {preq_sync_r[0], program_req};
      end
   end

   wire ea_synced = ea_sync_r[1];
   wire vreq_synced = vreq_sync_r[1];
   wire preq_synced = preq_sync_r[1];

   // ==========================================================
   // settle counter
   // capture waits until the pin has passed both stages; taking it on
   // the first edge would latch the sync reset value, not the pin
   logic [1:0] settle_r;
   wire settled = (settle_r == `SETTLE_DONE);
   wire [1:0] settle_nxt = settled ? settle_r
                                   : settle_r - `SETTLE_STEP;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         settle_r <= `SETTLE_START;
      end else begin
         settle_r <= settle_nxt;
      end
   end

   // ==========================================================
   // level decode
   function automatic lock_level_t decode_level(input logic [7:0] b);
      logic one;
      logic two;
      logic three;
      one = ~b[`LOCK_POS_ONE]; // RQ10
      two = ~b[`LOCK_POS_TWO];
      three = ~b[`LOCK_POS_THREE];
      // bit two alone is ignored; undefined mixes fall to nearest safe level
      if (!one) decode_level = LVL_OPEN; // RQ8
      else if (two && three) decode_level = LVL_ALL;
      else if (two) decode_level = LVL_TWO;
      else decode_level = LVL_ONE; // RQ7
   endfunction

   // ==========================================================
   // one-shot capture of level, pin and key state
   // until capture every grant stays shut, so nothing leaks early
   logic sample_r;
   lock_level_t level_r;
   logic ea_hold_r;
   logic key_on_r;
   wire lock_level_t level_nxt = decode_level(lock_byte);
   wire capture_now = sample_r && settled; // RQ12

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sample_r <= 1'h1;
      end else if (capture_now) begin
         sample_r <= 1'h0;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         level_r <= LVL_ALL;
      end else if (capture_now) begin
         level_r <= level_nxt; // RQ12
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ea_hold_r <= 1'h0;
      end else if (capture_now) begin
         ea_hold_r <= ea_synced; // RQ3
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         key_on_r <= 1'h0;
      end else if (capture_now) begin
         key_on_r <= key_programmed; // RQ1
      end
   end

   wire lvl_one_up = (level_r != LVL_OPEN);
   wire lvl_two_up = (level_r == LVL_TWO) || (level_r == LVL_ALL);
   wire lvl_all = (level_r == LVL_ALL);

   // ==========================================================
   // grants
   // key and lock bytes never leave the part
   wire ea_now = lvl_one_up ? ea_hold_r : ea_synced; // RQ3
   wire in_code = (verify_addr <= `IMG_CODE_LAST); // RQ9
   wire key_used = key_on_r && (key_byte != `KEY_BLANK); // RQ9
   wire verify_ok = vreq_synced && !lvl_two_up && !sample_r; // RQ1 RQ5
   wire verify_grant = verify_ok && in_code; // RQ11
   wire [7:0] plain_or_enc = key_used ? ~(code_byte ^ key_byte)
                                      : code_byte; // RQ11
   wire [7:0] verify_nxt = verify_grant ? plain_or_enc
                                        : `BYTE_ZERO; // RQ11
   wire table_nxt = code_table_read_instr && !sample_r &&
                    !(fetch_from_external && lvl_one_up); // RQ2
   wire prog_nxt = preq_synced && !lvl_one_up && !sample_r; // RQ4
   wire ext_nxt = ext_fetch_req && !lvl_all && !sample_r; // RQ6
   // level shows zero until capture, then the captured value
   wire [3:0] shown_nxt = capture_now ? level_nxt : lock_level; // RQ12

   // ==========================================================
   // output flops
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         verify_data <= `BYTE_ZERO;
      end else begin
         verify_data <= verify_nxt;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         verify_valid <= 1'h0;
      end else begin
         verify_valid <= verify_grant;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         program_allow <= 1'h0;
      end else begin
         program_allow <= prog_nxt;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         table_read_allow <= 1'h0;
      end else begin
         table_read_allow <= table_nxt;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ext_exec_allow <= 1'h0;
      end else begin
         ext_exec_allow <= ext_nxt;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ea_latched <= 1'h0;
      end else begin
         ea_latched <= ea_now;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         lock_level <= `LEVEL_NONE;
      end else begin
         lock_level <= shown_nxt;
      end
   end
endmodule // code_security_lock

// File: sim/code_lock_props.sv
`timescale 1ns/10ps
// ======
// lock checks
module code_lock_props(
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // stimulus at the block's inputs
   input wire logic verify_req,
   input wire logic code_table_read_instr,
   input wire logic fetch_from_external,
   input wire logic [7:0] lock_byte,
   // grants and status
   input wire logic verify_valid,
   input wire logic program_allow,
   input wire logic table_read_allow,
   input wire logic ext_exec_allow,
   input wire logic ea_latched,
   input wire logic [3:0] lock_level
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // locked twice in a row, so a late pin capture is not flagged
   sequence s_held; |lock_level[3:1] ##1 |lock_level[3:1]; endsequence
   property p_tbl; code_table_read_instr && fetch_from_external
      && !lock_level[0] |=> !table_read_allow; endproperty
   property p_prog; !lock_level[0] |-> !program_allow; endproperty
   property p_ext; lock_level[3] |-> !ext_exec_allow; endproperty
   property p_ver; |lock_level[3:2] |-> !verify_valid; endproperty
   property p_req; verify_valid |-> $past(verify_req, 3); endproperty
   property p_lvl; |lock_level |=> $stable(lock_level); endproperty
   property p_dec; |lock_level |-> lock_level[0] == lock_byte[0]; endproperty
   property p_ea; s_held |=> $stable(ea_latched); endproperty
   a_tbl: assert property (p_tbl) else $error("table read open");
   a_prog: assert property (p_prog) else $error("program open");
   a_ext: assert property (p_ext) else $error("ext exec open");
   a_ver: assert property (p_ver) else $error("verify open");
   a_req: assert property (p_req) else $error("stray verify");
   a_lvl: assert property (p_lvl) else $error("level moved");
   a_dec: assert property (p_dec) else $error("bad decode");
   a_ea: assert property (p_ea) else $error("pin not held");
endmodule // code_lock_props
bind code_security_lock code_lock_props u_props (.*);

// File: sim/code_image_model.sv
`timescale 1ns/10ps
// ======
// image model
module code_image_model(
   // address and key state from the bench
   input wire logic [14:0] verify_addr,
   input wire logic key_on,
   // image bytes
   output logic [7:0] code_byte,
   output logic [7:0] key_byte
);
   // row 3F stays blank so a keyed part still shows a plain byte
   assign code_byte = verify_addr[7:0] ^ 8'h5A;
   assign key_byte = key_on && verify_addr[5:0] != 6'h3F ?
      {2'h1, verify_addr[5:0]} : 8'hFF;
endmodule // code_image_model

// File: sim/tb_code_security_lock.sv
`timescale 1ns/10ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin bad_count++; \
   $display("MISMATCH %s exp %h got %h", n, e, s); end end
// ======
// bench
module tb_code_security_lock;
   logic mclk = 0, rst_n = 0, key_programmed = 0, external_access_pin = 0;
   logic verify_req = 0, program_req = 0, fetch_from_external = 0, old;
   logic code_table_read_instr = 1, ext_fetch_req = 1;
   logic verify_valid, program_allow, table_read_allow, ext_exec_allow;
   logic ea_latched;
   logic [7:0] lock_byte = 8'hFF, code_byte, key_byte, verify_data;
   logic [14:0] verify_addr = 0;
   logic [3:0] lock_level;
   int bad_count = 0, checked = 0, cyc = 0;
   logic [7:0] pats [5] = '{8'hFF, 8'hFE, 8'hFC, 8'hF8, 8'hFD};
   wire [11:0] seen = {verify_valid, verify_data, program_allow,
      table_read_allow, ext_exec_allow};
   code_image_model model (.verify_addr, .key_on(key_programmed),
      .code_byte, .key_byte);
   code_security_lock dut (.mclk, .rst_n, .lock_byte, .key_programmed,
      .external_access_pin, .verify_req, .verify_addr, .code_byte,
      .key_byte, .program_req, .code_table_read_instr,
      .fetch_from_external, .ext_fetch_req, .verify_data, .verify_valid,
      .program_allow, .table_read_allow, .ext_exec_allow, .ea_latched,
      .lock_level);
   function automatic logic [11:0] expect_out();
      logic v = (lock_byte[0] | lock_byte[1]) && verify_addr <= 15'h3FFF;
      return {v, !v ? 8'h00 : key_programmed && key_byte != 8'hFF ?
         ~(code_byte ^ key_byte) : code_byte, lock_byte[0],
         code_table_read_instr & (lock_byte[0] | !fetch_from_external),
         ext_fetch_req & (|lock_byte[2:0])};
   endfunction
   function automatic logic [3:0] expect_level();
      return lock_byte[0] ? 4'h1 : lock_byte[1] ? 4'h2 :
         lock_byte[2] ? 4'h4 : 4'h8;
   endfunction
   task stop_test;
      $display("compares %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial forever #4 mclk = ~mclk;
   always @(posedge mclk) if (++cyc == 1000) begin
      bad_count++;
      stop_test;
   end
   initial begin
      void'($urandom(32'h4827B9AA));
      for (int i = 0; i < 10; i++) begin
         @(posedge mclk);
         {rst_n, verify_req, program_req} <= 3'h0;
         lock_byte <= pats[i % 5];
         key_programmed <= i > 4;
         external_access_pin <= 1'($urandom);
         fetch_from_external <= i % 3 != 0;
         code_table_read_instr <= i % 4 != 1 || 1'($urandom);
         ext_fetch_req <= i % 4 != 2 || 1'($urandom);
         verify_addr <= i == 0 ? 15'h3FFF : i == 5 ? 15'h4005 :
            i == 9 ? 15'h013F : 15'($urandom & 32'h3FFF);
         repeat (3) @(posedge mclk);
         rst_n <= 1;
         @(posedge mclk);
         {verify_req, program_req} <= 2'h3;
         repeat (6) @(posedge mclk);
         #1 `CHK("grants", expect_out(), seen)
         `CHK("level", expect_level(), lock_level)
         old = external_access_pin;
         @(posedge mclk) external_access_pin <= ~old;
         repeat (4) @(posedge mclk);
         #1 `CHK("ea", lock_byte[0] ? ~old : old, ea_latched)
      end
      stop_test;
   end
endmodule // tb_code_security_lock
